// *** hw/rx_status_pkg.sv ***
package rx_status_pkg;

  // ****************************************************************
  // Register map (indices; byte address is four times each)
  // ****************************************************************
  localparam logic [7:0] IDX_FILL_CFG  = 8'h08;
  localparam logic [7:0] IDX_INT_MASK  = 8'h0a;
  localparam logic [7:0] IDX_INT_STAT  = 8'h0b;
  localparam logic [7:0] IDX_RX_STATUS = 8'h0c;
  localparam int         ADDR_W        = 12;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int         FILL_ZERO_BIT   = 5;
  localparam int         IGNORE_INV_BIT  = 6;
  localparam logic [7:0] FILL_CFG_RESET  = 8'h00;
  localparam logic [7:0] INT_MASK_RESET  = 8'h00;
  localparam logic [7:0] INT_STAT_RESET  = 8'h00;

  localparam int EV_LOCK    = 0;
  localparam int EV_INVALID = 1;
  localparam int EV_CHAN_STAT_REFRESH_FLAG    = 2;
  localparam int EV_CORRUPT = 3;
  localparam int EV_KIND    = 4;
  localparam int EV_COPY    = 5;
  localparam int EV_EMPH    = 6;
  localparam int EV_RATE    = 7;

  localparam int ST_AUDIO_N = 0;
  localparam int ST_PCM_N   = 1;
  localparam int ST_COPY    = 2;
  localparam int ST_EMPH    = 3;
  localparam int ST_RATE_LO = 4;
  localparam int ST_UNLOCK  = 6;

  // ****************************************************************
  // Burst sync detection
  // ****************************************************************
  localparam logic [15:0] SYNC_PA         = 16'hf872;
  localparam logic [15:0] SYNC_PB         = 16'h4e1f;
  localparam logic [2:0]  SYNC_ZERO_WORDS = 3'h4;
  localparam int          SAMPLE_W        = 24;
  localparam int          PCM_HOLD_SUBFRAMES = 8192;

  typedef enum logic [1:0] {
    SYNC_ZEROS = 2'b01,
    SYNC_WAIT_PB = 2'b10
  } sync_state_t;

  // Sub-frame as delivered by the biphase decoder
  typedef struct packed {
    logic                strobe;
    logic [SAMPLE_W-1:0] data;
    logic                invalid;
    logic                biphase_err;
    logic                parity_err;
    logic                preamble_err;
  } subframe_t;

  // Recovered channel-status and lock state
  typedef struct packed {
    logic       audio_n;
    logic       no_copyright_flag;
    logic       pre_emphasis_flag;
    logic [1:0] recovered_rate_class;
    logic       unlock;
    logic       chan_stat_refresh_flag;
  } rx_state_t;

  typedef struct packed {
    logic                valid;
    logic [SAMPLE_W-1:0] data;
  } sample_out_t;

endpackage : rx_status_pkg

// *** hw/rx_status_handler.sv ***
`timescale 1ns/100ps
module rx_status_handler #(
  parameter int PCM_HOLD = rx_status_pkg::PCM_HOLD_SUBFRAMES
) (
  input  wire logic                                pclk,
  input  wire logic                                presetn,
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [rx_status_pkg::ADDR_W-1:0]    paddr,
  input  wire logic [31:0]                         pwdata,
  output logic      [31:0]                         prdata,
  output logic                                     pready,
  output logic                                     pslverr,
  input  wire rx_status_pkg::subframe_t            sf_in,
  input  wire rx_status_pkg::rx_state_t            rx_state,
  output rx_status_pkg::sample_out_t               aif_out,
  output rx_status_pkg::sample_out_t               tx_out,
  output logic                                     non_audio,
  output logic                                     irq_n
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0]                  fill_cfg_r;
  logic [7:0]                  int_mask_r;
  logic [7:0]                  interrupt_status_reg_r;
  logic [7:0]                  interrupt_status_reg_nxt;
  logic [31:0]                 prdata_r;
  logic                        pready_r;
  logic                        pslverr_r;
  logic                        irq_n_r;
  logic                        non_audio_r;
  logic                        pcm_n_r;
  logic                        subframe_corrupt_flag_r;
  logic                        invalid_flag_r;
  rx_status_pkg::rx_state_t    prev_state_r;
  logic                        prev_pcm_n_r;
  logic                        prev_audio_n_r;
  rx_status_pkg::sample_out_t  aif_r;
  rx_status_pkg::sample_out_t  tx_r;
  logic [rx_status_pkg::SAMPLE_W-1:0] last_aif_r;
  logic [rx_status_pkg::SAMPLE_W-1:0] last_tx_r;
  rx_status_pkg::sync_state_t  sync_state_r;
  logic [2:0]                  zero_cnt_r;
  logic [13:0]                 pcm_hold_cnt_r;

  logic [7:0]  receiver_status;
  logic [7:0]  raw_ev;
  logic [7:0]  ev;
  logic        rd_take;
  logic        wr_done;
  logic [7:0]  reg_idx;
  logic        idx_ok;
  logic        corrupt_now;
  logic        ignore_invalid_marking;
  logic        zero_fill_select;
  logic        aif_replace;
  logic        tx_replace;
  logic        sync_hit;
  logic [15:0] sf_word;

  assign zero_fill_select       = fill_cfg_r[rx_status_pkg::FILL_ZERO_BIT];
  assign ignore_invalid_marking = fill_cfg_r[rx_status_pkg::IGNORE_INV_BIT];

  // Sample chosen when a replacement is due
  function automatic logic [rx_status_pkg::SAMPLE_W-1:0] fill_sample(
    input logic                                zero,
    input logic [rx_status_pkg::SAMPLE_W-1:0] last
  );
    fill_sample = zero ? '0 : last;
  endfunction : fill_sample

  // ****************************************************************
  // APB slave: one wait state, read data captured with the clear
  // ****************************************************************
  assign reg_idx = paddr[9:2];
  assign idx_ok  = (paddr[1:0] == 2'b00) && (paddr[rx_status_pkg::ADDR_W-1:10] == '0) &&
                   ((reg_idx == rx_status_pkg::IDX_FILL_CFG) ||
                    (reg_idx == rx_status_pkg::IDX_INT_MASK) ||
                    (reg_idx == rx_status_pkg::IDX_INT_STAT) ||
                    (reg_idx == rx_status_pkg::IDX_RX_STATUS));
  assign rd_take = psel && penable && !pready_r && !pwrite;
  assign wr_done = psel && penable && pready_r && pwrite && idx_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= psel && penable && !pready_r;
      pslverr_r <= psel && penable && !pready_r && !idx_ok;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (rd_take) begin
      case (reg_idx)
        rx_status_pkg::IDX_FILL_CFG:  prdata_r <= {24'h00_0000, fill_cfg_r};
        rx_status_pkg::IDX_INT_MASK:  prdata_r <= {24'h00_0000, int_mask_r};
        rx_status_pkg::IDX_INT_STAT:  prdata_r <= {24'h00_0000, interrupt_status_reg_r};
        rx_status_pkg::IDX_RX_STATUS: prdata_r <= {24'h00_0000, receiver_status};
        default:                      prdata_r <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fill_cfg_r <= rx_status_pkg::FILL_CFG_RESET;
      int_mask_r <= rx_status_pkg::INT_MASK_RESET;
    end else if (wr_done) begin
      if (reg_idx == rx_status_pkg::IDX_FILL_CFG) begin
        fill_cfg_r <= pwdata[7:0];
      end
      if (reg_idx == rx_status_pkg::IDX_INT_MASK) begin
        int_mask_r <= pwdata[7:0];
      end
    end
  end

  // ****************************************************************
  // Receiver status word
  // ****************************************************************
  always_comb begin
    receiver_status = 8'h00;
    receiver_status[rx_status_pkg::ST_AUDIO_N] = rx_state.audio_n;
    receiver_status[rx_status_pkg::ST_PCM_N]   = pcm_n_r;
    receiver_status[rx_status_pkg::ST_COPY]    = rx_state.no_copyright_flag;
    receiver_status[rx_status_pkg::ST_EMPH]    = rx_state.pre_emphasis_flag;
    receiver_status[rx_status_pkg::ST_RATE_LO +: 2] = rx_state.recovered_rate_class;
    receiver_status[rx_status_pkg::ST_UNLOCK]  = rx_state.unlock;
  end

  // ****************************************************************
  // Burst sync detection on the top 16 bits of each sub-frame
  // ****************************************************************
  assign sf_word  = sf_in.data[rx_status_pkg::SAMPLE_W-1 -: 16];
  assign sync_hit = sf_in.strobe && (sync_state_r == rx_status_pkg::SYNC_WAIT_PB) &&
                    (sf_word == rx_status_pkg::SYNC_PB);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_state_r <= rx_status_pkg::SYNC_ZEROS;
      zero_cnt_r   <= 3'h0;
    end else if (sf_in.strobe) begin
      case (sync_state_r)
        rx_status_pkg::SYNC_ZEROS: begin
          if (sf_word == 16'h0000) begin
            if (zero_cnt_r != rx_status_pkg::SYNC_ZERO_WORDS) begin
              zero_cnt_r <= zero_cnt_r + 3'h1;
            end
          end else if (zero_cnt_r == rx_status_pkg::SYNC_ZERO_WORDS &&
                       sf_word == rx_status_pkg::SYNC_PA) begin
            sync_state_r <= rx_status_pkg::SYNC_WAIT_PB;
            zero_cnt_r   <= 3'h0;
          end else begin
            zero_cnt_r <= 3'h0;
          end
        end
        rx_status_pkg::SYNC_WAIT_PB: begin
          sync_state_r <= rx_status_pkg::SYNC_ZEROS;
          zero_cnt_r   <= (sf_word == 16'h0000) ? 3'h1 : 3'h0;
        end
        default: begin
          sync_state_r <= rx_status_pkg::SYNC_ZEROS;
          zero_cnt_r   <= 3'h0;
        end
      endcase
    end
  end

  // Non-PCM falls back to zero only after a long run without sync,
  // so bursts spaced far apart do not make the flag chatter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pcm_n_r        <= 1'b0;
      pcm_hold_cnt_r <= 14'h0000;
    end else if (sync_hit) begin
      pcm_n_r        <= 1'b1;
      pcm_hold_cnt_r <= 14'h0000;
    end else if (sf_in.strobe && pcm_n_r) begin
      if (pcm_hold_cnt_r == 14'(PCM_HOLD - 1)) begin
        pcm_n_r <= 1'b0;
      end else begin
        pcm_hold_cnt_r <= pcm_hold_cnt_r + 14'h0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      non_audio_r <= 1'b0;
    end else begin
      non_audio_r <= rx_state.audio_n | pcm_n_r;
    end
  end

  // ****************************************************************
  // Error flags, held from one sub-frame to the next
  // ****************************************************************
  assign corrupt_now = sf_in.biphase_err | sf_in.parity_err | sf_in.preamble_err;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      subframe_corrupt_flag_r <= 1'b0;
      invalid_flag_r          <= 1'b0;
    end else if (sf_in.strobe) begin
      subframe_corrupt_flag_r <= corrupt_now;
      invalid_flag_r          <= sf_in.invalid;
    end
  end

  // ****************************************************************
  // Event detection and latching
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_state_r   <= '0;
      prev_pcm_n_r   <= 1'b0;
      prev_audio_n_r <= 1'b0;
    end else begin
      prev_state_r   <= rx_state;
      prev_pcm_n_r   <= pcm_n_r;
      prev_audio_n_r <= rx_state.audio_n;
    end
  end

  always_comb begin
    raw_ev = 8'h00;
    raw_ev[rx_status_pkg::EV_LOCK]    = rx_state.unlock ^ prev_state_r.unlock;
    raw_ev[rx_status_pkg::EV_INVALID] = invalid_flag_r;
    raw_ev[rx_status_pkg::EV_CHAN_STAT_REFRESH_FLAG]    = rx_state.chan_stat_refresh_flag &&
                                        !prev_state_r.chan_stat_refresh_flag;
    raw_ev[rx_status_pkg::EV_CORRUPT] = subframe_corrupt_flag_r;
    raw_ev[rx_status_pkg::EV_KIND]    = (rx_state.audio_n ^ prev_audio_n_r) |
                                        (pcm_n_r ^ prev_pcm_n_r);
    raw_ev[rx_status_pkg::EV_COPY]    = rx_state.no_copyright_flag ^
                                        prev_state_r.no_copyright_flag;
    raw_ev[rx_status_pkg::EV_EMPH]    = rx_state.pre_emphasis_flag ^
                                        prev_state_r.pre_emphasis_flag;
    raw_ev[rx_status_pkg::EV_RATE]    = |(rx_state.recovered_rate_class &
                                          ~prev_state_r.recovered_rate_class);
  end

  assign ev = raw_ev & ~int_mask_r;

  // Clear on the capture edge of the read; a same-cycle event survives
  always_comb begin
    interrupt_status_reg_nxt = interrupt_status_reg_r;
    if (rd_take && reg_idx == rx_status_pkg::IDX_INT_STAT && idx_ok) begin
      interrupt_status_reg_nxt = 8'h00;
    end
    interrupt_status_reg_nxt = interrupt_status_reg_nxt | ev;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_status_reg_r <= rx_status_pkg::INT_STAT_RESET;
    end else begin
      interrupt_status_reg_r <= interrupt_status_reg_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_n_r <= 1'b1;
    end else begin
      irq_n_r <= ~(|interrupt_status_reg_r);
    end
  end

  // ****************************************************************
  // Sample paths with substitution
  // ****************************************************************
  assign aif_replace = (corrupt_now && int_mask_r[rx_status_pkg::EV_CORRUPT]) ||
                       (sf_in.invalid && int_mask_r[rx_status_pkg::EV_INVALID] &&
                        !ignore_invalid_marking);
  assign tx_replace  = sf_in.invalid && int_mask_r[rx_status_pkg::EV_INVALID] &&
                       !ignore_invalid_marking;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aif_r      <= '0;
      last_aif_r <= '0;
    end else begin
      aif_r.valid <= sf_in.strobe;
      if (sf_in.strobe) begin
        if (aif_replace) begin
          aif_r.data <= fill_sample(zero_fill_select, last_aif_r);
        end else begin
          aif_r.data <= sf_in.data;
          last_aif_r <= sf_in.data;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_r      <= '0;
      last_tx_r <= '0;
    end else begin
      tx_r.valid <= sf_in.strobe;
      if (sf_in.strobe) begin
        if (tx_replace) begin
          tx_r.data <= fill_sample(zero_fill_select, last_tx_r);
        end else begin
          tx_r.data <= sf_in.data;
          last_tx_r <= sf_in.data;
        end
      end
    end
  end

  assign prdata    = prdata_r;
  assign pready    = pready_r;
  assign pslverr   = pslverr_r;
  assign aif_out   = aif_r;
  assign tx_out    = tx_r;
  assign non_audio = non_audio_r;
  assign irq_n     = irq_n_r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic rd_status;
  assign rd_status = rd_take && idx_ok && reg_idx == rx_status_pkg::IDX_RX_STATUS;

  chk_status_audio: assert property (@(posedge pclk) disable iff (!presetn)
    rd_status |=> prdata_r[0] == $past(rx_state.audio_n))
    else $error("status bit 0 not audio flag");

  chk_status_pcm: assert property (@(posedge pclk) disable iff (!presetn)
    rd_status |=> prdata_r[1] == $past(pcm_n_r))
    else $error("status bit 1 not sync flag");

  chk_status_rate: assert property (@(posedge pclk) disable iff (!presetn)
    rd_status |=> prdata_r[5:4] == $past(rx_state.recovered_rate_class))
    else $error("status rate field wrong");

  chk_status_lock: assert property (@(posedge pclk) disable iff (!presetn)
    rd_status |=> prdata_r[6] == $past(rx_state.unlock))
    else $error("status unlock bit wrong");

  chk_mask_blocks: assert property (@(posedge pclk) disable iff (!presetn)
    (int_mask_r[3] && !interrupt_status_reg_r[3]) |=> !interrupt_status_reg_r[3])
    else $error("masked flag set status");

  chk_corrupt_event: assert property (@(posedge pclk) disable iff (!presetn)
    (sf_in.strobe && sf_in.parity_err && !int_mask_r[3]) ##1 !int_mask_r[3]
      |=> interrupt_status_reg_r[3])
    else $error("corrupt sub-frame not reported");

  chk_pass_through: assert property (@(posedge pclk) disable iff (!presetn)
    (sf_in.strobe && int_mask_r[3:0] == 4'h0) |=> aif_r.valid && aif_r.data == $past(sf_in.data))
    else $error("unmasked sample altered");

  chk_zero_fill: assert property (@(posedge pclk) disable iff (!presetn)
    (sf_in.strobe && sf_in.biphase_err && int_mask_r[3] && zero_fill_select)
      |=> aif_r.data == '0)
    else $error("zero fill not applied");

  chk_tx_ignores_corrupt: assert property (@(posedge pclk) disable iff (!presetn)
    (sf_in.strobe && !sf_in.invalid) |=> tx_r.data == $past(sf_in.data))
    else $error("tx sample altered without invalid");

  chk_latch_holds: assert property (@(posedge pclk) disable iff (!presetn)
    (interrupt_status_reg_r[0] && !rd_take) |=> interrupt_status_reg_r[0])
    else $error("status bit lost without read");

  chk_irq_follows: assert property (@(posedge pclk) disable iff (!presetn)
    (|interrupt_status_reg_r) |=> !irq_n_r ##1 (irq_n_r == !$past(|interrupt_status_reg_r)))
    else $error("interrupt line wrong");

  cov_sync_found: cover property (@(posedge pclk) disable iff (!presetn) sync_hit);
  cov_repeat_fill: cover property (@(posedge pclk) disable iff (!presetn)
    sf_in.strobe && aif_replace && !zero_fill_select);
  cov_read_clear: cover property (@(posedge pclk) disable iff (!presetn)
    interrupt_status_reg_r != 8'h00 ##1 interrupt_status_reg_r == 8'h00);

endmodule : rx_status_handler

// *** dv/audio_src_model.sv ***
`timescale 1ns/100ps
module audio_src_model (
  input  wire logic                pclk,
  output rx_status_pkg::subframe_t sf_in,
  output rx_status_pkg::rx_state_t rx_state
);
  int sent;

  initial begin
    sent     = 0;
    sf_in    = '0;
    rx_state = '0;
  end

  // k = {invalid, biphase, parity, preamble}
  task automatic send(input logic [23:0] d, input logic [3:0] k);
    @(posedge pclk);
    sf_in <= {1'b1, d, k};
    sent  <= sent + 1;
    @(posedge pclk);
    // Line released: show junk, never a stale copy
    sf_in <= {1'b0, ~d, ~k};
    repeat (2) @(posedge pclk);
  endtask : send

  task automatic set_state(input logic [6:0] s);
    @(posedge pclk);
    rx_state <= s;
    repeat (3) @(posedge pclk);
  endtask : set_state
endmodule : audio_src_model

// *** dv/spdif_rx_status_error_handler_tb_top.sv ***
`timescale 1ns/100ps
module spdif_rx_status_error_handler_tb_top;
  logic                        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0]                 paddr;
  logic [31:0]                 pwdata, prdata, rd;
  logic                        non_audio, irq_n;
  rx_status_pkg::subframe_t    sf_in;
  rx_status_pkg::rx_state_t    rx_state;
  rx_status_pkg::sample_out_t  aif_out, tx_out;
  int                          failures, samples_checked, cycles;
  int                          aif_pulses, tx_pulses;

  rx_status_handler #(.PCM_HOLD(16)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sf_in(sf_in), .rx_state(rx_state),
    .aif_out(aif_out), .tx_out(tx_out), .non_audio(non_audio), .irq_n(irq_n));
  audio_src_model i_src (.pclk(pclk), .sf_in(sf_in), .rx_state(rx_state));

  initial pclk = 1'b0;
  always #2 pclk = ~pclk;

  // Valid pulses last one cycle, so count them as they pass
  always @(posedge pclk) begin
    if (aif_out.valid === 1'b1) aif_pulses <= aif_pulses + 1;
    if (tx_out.valid === 1'b1) tx_pulses <= tx_pulses + 1;
  end

  // ****************************************************************
  // Bus and compare tasks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    // Only the cycle ceiling ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rdc

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  // Run is a few hundred cycles; ceiling leaves wide margin
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      print_verdict();
    end
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {failures, samples_checked, cycles, aif_pulses, tx_pulses} = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdc(12'h020, 32'h0);
    rdc(12'h028, 32'h0);
    rdc(12'h02c, 32'h0);
    rdc(12'h004, 32'h0);
    check({31'h0, err}, 32'h1);
    $display("end of test: reset and map");
    i_src.set_state(7'b1111010);
    rdc(12'h030, 32'h6d);
    check({31'h0, irq_n}, 32'h0);
    rdc(12'h02c, 32'hf1);
    rdc(12'h02c, 32'h00);
    repeat (3) @(posedge pclk);
    check({31'h0, irq_n}, 32'h1);
    $display("end of test: status and events");
    apb(1'b1, 12'h028, 32'hff);
    i_src.set_state(7'b0000000);
    rdc(12'h02c, 32'h00);
    check({31'h0, irq_n}, 32'h1);
    apb(1'b1, 12'h028, 32'h00);
    i_src.set_state(7'b0000001);
    rdc(12'h02c, 32'h04);
    rdc(12'h02c, 32'h00);
    $display("end of test: mask and edges");
    apb(1'b1, 12'h028, 32'h0a);
    apb(1'b1, 12'h020, 32'h00);
    i_src.send(24'habcdef, 4'b0000);
    for (int i = 0; i < 3; i++) begin
      i_src.send(24'h100000 + 24'(i), 4'b0100 >> i);
      check({8'h0, aif_out.data}, 32'habcdef);
      check({8'h0, tx_out.data}, 32'h100000 + i);
    end
    i_src.send(24'h777777, 4'b1000);
    check({8'h0, aif_out.data}, 32'habcdef);
    check({8'h0, tx_out.data}, 32'h100002);
    apb(1'b1, 12'h020, 32'h20);
    i_src.send(24'h555555, 4'b1000);
    check({8'h0, aif_out.data}, 32'h0);
    check({8'h0, tx_out.data}, 32'h0);
    i_src.send(24'h666666, 4'b0010);
    check({8'h0, aif_out.data}, 32'h0);
    check({8'h0, tx_out.data}, 32'h666666);
    apb(1'b1, 12'h020, 32'h40);
    i_src.send(24'h888888, 4'b1000);
    check({aif_out.data[15:0], tx_out.data[15:0]}, 32'h88888888);
    rdc(12'h02c, 32'h00);
    $display("end of test: substitution");
    apb(1'b1, 12'h028, 32'h00);
    apb(1'b1, 12'h020, 32'h00);
    i_src.send(24'h13579b, 4'b1010);
    check({8'h0, aif_out.data}, 32'h13579b);
    check({8'h0, tx_out.data}, 32'h13579b);
    rdc(12'h02c, 32'h0a);
    rdc(12'h02c, 32'h0a);
    i_src.send(24'h010203, 4'b0000);
    apb(1'b0, 12'h02c, 32'h0);
    rdc(12'h02c, 32'h00);
    $display("end of test: unmasked errors");
    for (int i = 0; i < 6; i++)
      i_src.send(i < 4 ? 24'h0 : (i == 4 ? 24'hf87200 : 24'h4e1f00), 4'b0000);
    rdc(12'h030, 32'h02);
    check({31'h0, non_audio}, 32'h1);
    rdc(12'h02c, 32'h10);
    for (int i = 0; i < 17; i++)
      i_src.send(24'h010203, 4'b0000);
    rdc(12'h030, 32'h00);
    check({31'h0, non_audio}, 32'h0);
    $display("end of test: sync detect");
    check(aif_pulses, i_src.sent);
    check(tx_pulses, i_src.sent);
    $display("end of test: sample pulses");
    print_verdict();
  end
endmodule : spdif_rx_status_error_handler_tb_top
